// [common/spbw_map.svh]
`ifndef SPBW_MAP_SVH
`define SPBW_MAP_SVH

// Register byte offsets on the AHB-Lite slave.
`define SPBW_OFS_CMD_LO 8'h00
`define SPBW_OFS_CMD_HI 8'h04
`define SPBW_OFS_XDATA 8'h08
`define SPBW_OFS_CTRL 8'h0C
`define SPBW_OFS_LINES 8'h10
`define SPBW_OFS_STATUS 8'h14

// Field positions.
`define SPBW_CTRL_GO_BIT 31
`define SPBW_CTRL_CNT_LSB 0
`define SPBW_CTRL_DEL_LSB 8
`define SPBW_SEL_PORTB_BIT 3
`define SPBW_SEL_POS_BIT 4
`define SPBW_STAT_BUSY_BIT 0
`define SPBW_STAT_DONE_BIT 1
`define SPBW_STAT_ERR_BIT 2
`define SPBW_STAT_RESP_LSB 8
`define SPBW_STAT_RD_LSB 16

// Command encodings.
`define SPBW_OP_STROBED_WRITE 8'h0B
`define SPBW_OP_STROBED_READ 8'h0C
`define SPBW_PORT_MAX 8'h01
`define SPBW_SEL_MAX 8'h1F

// Reset values.
`define SPBW_REG_RST 32'h0000_0000
`define SPBW_BYTE_RST 8'h00

// Timing: strobe width spans the minimum at len 0 to the maximum at len 255.
`define SPBW_HCLK_MHZ 100
`define SPBW_STROBE_MIN_NS 10000
`define SPBW_STROBE_MAX_NS 200000
`define SPBW_LEN_STEPS 255
`define SPBW_GAP_UNIT_NS 1000

`endif

// [common/spbw_pkg.sv]
package spbw_pkg;

   // Single operations performed by the pin engine in the link domain.
   typedef enum logic [2:0] {
      STEP_PRESET  = 3'h0,
      STEP_DRIVE   = 3'h1,
      STEP_ASSERT  = 3'h2,
      STEP_RELEASE = 3'h3,
      STEP_SAMPLE  = 3'h4
   } spbw_step_e;

   // Sequencer states in the bus domain.
   typedef enum logic [2:0] {
      SEQ_IDLE    = 3'h0,
      SEQ_PRESET  = 3'h1,
      SEQ_DRIVE   = 3'h2,
      SEQ_ASSERT  = 3'h3,
      SEQ_HOLD    = 3'h4,
      SEQ_SAMPLE  = 3'h5,
      SEQ_RELEASE = 3'h6,
      SEQ_GAP     = 3'h7
   } spbw_seq_e;

   // Bus-domain state of the top module.
   typedef struct packed {
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] cmd_lo;
      logic [31:0] cmd_hi;
      logic [31:0] xdata;
      logic [31:0] lines;
      logic [1:0] cnt;
      logic [7:0] gap_del;
      logic busy;
      logic done;
      logic err;
      logic [7:0] resp0;
      logic [7:0] rd_byte;
      logic preset_pend;
      spbw_seq_e st;
      logic step_pend;
      logic req_tgl;
      logic ack_seen;
      spbw_step_e step;
      logic [7:0] data;
      logic [31:0] lines_x;
      logic [1:0] left;
      logic [23:0] xq;
      logic [19:0] timer;
   } spbw_top_s;

   // Link-domain state of the pin engine.
   typedef struct packed {
      logic req_seen;
      logic ack_tgl;
      logic [7:0] out_a;
      logic [7:0] out_b;
      logic [7:0] oe_a;
      logic [7:0] oe_b;
      logic saved;
      logic [7:0] sample;
   } spbw_port_s;

endpackage

// [common/spbw_if.sv]
`timescale 1ns/1ps
// Toggle handshake between the bus-domain sequencer and the link-domain pin engine.
interface spbw_if;
   logic req_tgl;
   logic ack_tgl;
   spbw_pkg::spbw_step_e step;
   logic [7:0] data;
   logic [3:0] line;
   logic pos;
   logic port_b;
   logic [31:0] lines;
   logic [7:0] sample;

   modport ctl (output req_tgl, step, data, line, pos, port_b, lines, input ack_tgl, sample);
   modport eng (input req_tgl, step, data, line, pos, port_b, lines, output ack_tgl, sample);
endinterface

// [hw/spbw_sync.sv]
`timescale 1ns/1ps
// Two-flop synchroniser; only the second stage is visible outside.
module spbw_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } spbw_sync_s;

   spbw_sync_s s;
   spbw_sync_s next_s;

   if (WIDTH < 1) begin : g_chk
      $error("spbw_sync needs WIDTH of at least one.");
   end

   // The meta stage feeds the stable stage and nothing else.
   always_comb
   begin
      next_s = s;
      next_s.meta = d;
      next_s.stable = s.meta;
   end

   // Both stages clear under reset.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign q = s.stable;
endmodule

// [hw/spbw_port.sv]
`timescale 1ns/1ps
// Link-domain pin engine: owns the port latches and executes one step per request toggle.
module spbw_port (
   input wire logic link_clk,
   input wire logic hresetn,
   spbw_if.eng lnk,
   input wire logic [7:0] port_a_in,
   input wire logic [7:0] port_b_in,
   output logic [7:0] port_a_out,
   output logic [7:0] port_a_oe,
   output logic [7:0] port_b_out,
   output logic [7:0] port_b_oe
);
   spbw_pkg::spbw_port_s s;
   spbw_pkg::spbw_port_s next_s;
   logic [1:0] rst_pipe;
   logic req_s;
   logic [7:0] pin_a_s;
   logic [7:0] pin_b_s;
   logic [15:0] all_out;
   logic [15:0] line_mask;

   // Reset asserts at once and releases two link edges later, so the engine never leaves reset mid-edge.
   always_ff @(posedge link_clk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rst_pipe <= 2'h0;
      end
      else
      begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end

   // The request toggle and both port inputs come from outside this clock.
   spbw_sync #(.WIDTH(17)) u_sync (
      .clk(link_clk),
      .rst_n(rst_pipe[1]),
      .d({lnk.req_tgl, port_a_in, port_b_in}),
      .q({req_s, pin_a_s, pin_b_s})
   );

   // Line code bit 3 picks port B, bits 2:0 pick the line.
   assign all_out = {s.out_b, s.out_a};
   assign line_mask = 16'h0001 << lnk.line;

   // Command fields are stable while a request is pending, so they are read only on the toggle edge.
   always_comb
   begin
      logic [15:0] upd;
      upd = all_out;
      next_s = s;
      if (req_s != s.req_seen)
      begin
         next_s.req_seen = req_s;
         next_s.ack_tgl = ~s.ack_tgl;
         case (lnk.step)
            spbw_pkg::STEP_PRESET:
            begin
               upd = lnk.lines[15:0];
               next_s.oe_a = lnk.lines[23:16];
               next_s.oe_b = lnk.lines[31:24];
            end
            spbw_pkg::STEP_DRIVE:
            begin
               // Data moves only here, so it stays put through the whole strobe.
               if (lnk.port_b)
               begin
                  upd[15:8] = lnk.data;
               end
               else
               begin
                  upd[7:0] = lnk.data;
               end
            end
            spbw_pkg::STEP_ASSERT:
            begin
               // Remember the preset level so release restores exactly it.
               next_s.saved = |(all_out & line_mask);
               upd = lnk.pos ? (all_out | line_mask) : (all_out & ~line_mask);
            end
            spbw_pkg::STEP_RELEASE:
            begin
               upd = s.saved ? (all_out | line_mask) : (all_out & ~line_mask);
            end
            spbw_pkg::STEP_SAMPLE:
            begin
               next_s.sample = lnk.port_b ? pin_b_s : pin_a_s;
            end
            default:
            begin
               upd = all_out;
            end
         endcase
      end
      next_s.out_a = upd[7:0];
      next_s.out_b = upd[15:8];
   end

   // Single state register for the engine.
   always_ff @(posedge link_clk or negedge rst_pipe[1])
   begin
      if (!rst_pipe[1])
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign lnk.ack_tgl = s.ack_tgl;
   assign lnk.sample = s.sample;
   assign port_a_out = s.out_a;
   assign port_b_out = s.out_b;
   assign port_a_oe = s.oe_a;
   assign port_b_oe = s.oe_b;
endmodule

// [hw/spbw_top.sv]
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "spbw_map.svh"

// Functional notes
// - Byte 0 opcode 0Bh, byte 1 data.
// - Byte 2 picks port A 00h, B 01h.
// - Byte 3 low codes pick strobe line.
// - Plus 10h makes strobe low-high-low.
// - Data driven first, then strobe pulsed.
// - Byte 4 lengthens active phase, 00h-FFh.
// - Pulse spans about 10 to 200 us.
// - Bytes 5 to 7 are ignored.
// - Response byte 0 echoes opcode.
// - Programmable delay between successive bytes.
// - Read: assert, sample port, restore line.
module spbw_top #(
   parameter int STROBE_BASE_CYC = (`SPBW_STROBE_MIN_NS * `SPBW_HCLK_MHZ + 999) / 1000,
   parameter int STROBE_STEP_CYC =
      ((`SPBW_STROBE_MAX_NS - `SPBW_STROBE_MIN_NS) * `SPBW_HCLK_MHZ / 1000) / `SPBW_LEN_STEPS,
   parameter int GAP_UNIT_CYC = (`SPBW_GAP_UNIT_NS * `SPBW_HCLK_MHZ) / 1000
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic link_clk,
   input wire logic [7:0] port_a_in,
   input wire logic [7:0] port_b_in,
   output logic [7:0] port_a_out,
   output logic [7:0] port_a_oe,
   output logic [7:0] port_b_out,
   output logic [7:0] port_b_oe
);
   spbw_pkg::spbw_top_s s;
   spbw_pkg::spbw_top_s next_s;
   spbw_if lnk ();
   logic ack_s;
   logic [7:0] opcode;
   logic [7:0] port_sel;
   logic [7:0] line_sel;
   logic cmd_ok;
   logic is_read;

   // The timer is 20 bits wide; refuse settings that would overflow it.
   if (STROBE_BASE_CYC < 1 || STROBE_STEP_CYC < 0 || GAP_UNIT_CYC < 1 ||
       STROBE_BASE_CYC + 255 * STROBE_STEP_CYC > 20'hFFFFF || 256 * GAP_UNIT_CYC > 20'hFFFFF) begin : g_chk
      $error("spbw_top timing parameters out of range.");
   end

   // Active-phase length in cycles minus one, from the length byte.
   function automatic logic [19:0] hold_cycles(input logic [7:0] len);
      hold_cycles = 20'(STROBE_BASE_CYC) + 20'(len) * 20'(STROBE_STEP_CYC) - 20'h00001;
   endfunction

   // Gap between bytes in cycles minus one; a zero setting still leaves one unit.
   function automatic logic [19:0] gap_cycles(input logic [7:0] del);
      gap_cycles = (20'(del) + 20'h00001) * 20'(GAP_UNIT_CYC) - 20'h00001;
   endfunction

   // Register read multiplexer; unmapped offsets read as zero.
   function automatic logic [31:0] read_reg(input logic [7:0] ofs, input spbw_pkg::spbw_top_s r);
      case (ofs)
         `SPBW_OFS_CMD_LO: read_reg = r.cmd_lo;
         `SPBW_OFS_CMD_HI: read_reg = r.cmd_hi;
         `SPBW_OFS_XDATA: read_reg = r.xdata;
         `SPBW_OFS_CTRL: read_reg = {16'h0000, r.gap_del, 6'h00, r.cnt};
         `SPBW_OFS_LINES: read_reg = r.lines;
         `SPBW_OFS_STATUS: read_reg = {8'h00, r.rd_byte, r.resp0, 5'h00, r.err, r.done, r.busy};
         default: read_reg = 32'h0000_0000;
      endcase
   endfunction

   // Ack toggle from the link domain is a level change and is synchronised.
   spbw_sync #(.WIDTH(1)) u_ack (
      .clk(hclk),
      .rst_n(hresetn),
      .d(lnk.ack_tgl),
      .q(ack_s)
   );

   spbw_port u_port (
      .link_clk(link_clk),
      .hresetn(hresetn),
      .lnk(lnk.eng),
      .port_a_in(port_a_in),
      .port_b_in(port_b_in),
      .port_a_out(port_a_out),
      .port_a_oe(port_a_oe),
      .port_b_out(port_b_out),
      .port_b_oe(port_b_oe)
   );

   // Packet fields; bytes 5 to 7 of the high word are stored but never read by the sequencer.
   assign opcode = s.cmd_lo[7:0];
   assign port_sel = s.cmd_lo[23:16];
   assign line_sel = s.cmd_lo[31:24];
   assign is_read = (opcode == `SPBW_OP_STROBED_READ);
   assign cmd_ok = (opcode == `SPBW_OP_STROBED_WRITE || is_read) && port_sel <= `SPBW_PORT_MAX &&
                   line_sel <= `SPBW_SEL_MAX;

   // Handshake fields held in flops, stable while a step is pending.
   assign lnk.req_tgl = s.req_tgl;
   assign lnk.step = s.step;
   assign lnk.data = s.data;
   assign lnk.line = line_sel[3:0];
   assign lnk.pos = line_sel[`SPBW_SEL_POS_BIT];
   assign lnk.port_b = port_sel[0];
   assign lnk.lines = s.lines_x;

   // Bus slave and sequencer share one next-state process.
   always_comb
   begin
      logic step_done;
      logic finish;
      step_done = 1'b0;
      finish = 1'b0;
      next_s = s;
      next_s.hreadyout = 1'b1;
      next_s.hresp = 1'b0;

      // Address phase: latch write target, prepare read data for the data phase.
      next_s.wr_pend = 1'b0;
      if (hsel && htrans[1] && hready && hsize == 3'h2)
      begin
         next_s.wr_pend = hwrite;
         next_s.wr_addr = haddr[7:0];
         if (!hwrite)
         begin
            next_s.hrdata = read_reg(haddr[7:0], s);
         end
      end

      // Data phase write. Packet registers are frozen while busy so the sequence sees one command.
      if (s.wr_pend)
      begin
         case (s.wr_addr)
            `SPBW_OFS_CMD_LO:
               if (!s.busy) next_s.cmd_lo = hwdata;
            `SPBW_OFS_CMD_HI:
               if (!s.busy) next_s.cmd_hi = hwdata;
            `SPBW_OFS_XDATA:
               if (!s.busy) next_s.xdata = hwdata;
            `SPBW_OFS_LINES:
            begin
               next_s.lines = hwdata;
               next_s.preset_pend = 1'b1;
            end
            `SPBW_OFS_CTRL:
               if (!s.busy)
               begin
                  next_s.cnt = hwdata[`SPBW_CTRL_CNT_LSB +: 2];
                  next_s.gap_del = hwdata[`SPBW_CTRL_DEL_LSB +: 8];
                  if (hwdata[`SPBW_CTRL_GO_BIT])
                  begin
                     next_s.done = 1'b0;
                     next_s.err = !cmd_ok;
                     next_s.busy = cmd_ok;
                     next_s.resp0 = `SPBW_BYTE_RST;
                  end
               end
            default:
            begin
               next_s.lines = s.lines;
            end
         endcase
      end

      // Step handshake: one toggle out, wait for the matching toggle back.
      if (s.step_pend && ack_s != s.ack_seen)
      begin
         next_s.ack_seen = ack_s;
         next_s.step_pend = 1'b0;
         step_done = 1'b1;
      end

      case (s.st)
         spbw_pkg::SEQ_IDLE:
         begin
            // A preset waiting in LINES goes first so the line is idle before any strobe.
            if (s.preset_pend)
            begin
               next_s.preset_pend = s.wr_pend && s.wr_addr == `SPBW_OFS_LINES; // A fresh write wins.
               next_s.lines_x = s.lines;
               next_s.step = spbw_pkg::STEP_PRESET;
               next_s.req_tgl = ~s.req_tgl;
               next_s.step_pend = 1'b1;
               next_s.st = spbw_pkg::SEQ_PRESET;
            end
            else if (s.busy)
            begin
               next_s.data = s.cmd_lo[15:8];
               next_s.left = s.cnt;
               next_s.xq = s.xdata[23:0];
               next_s.step = is_read ? spbw_pkg::STEP_ASSERT : spbw_pkg::STEP_DRIVE;
               next_s.req_tgl = ~s.req_tgl;
               next_s.step_pend = 1'b1;
               next_s.st = is_read ? spbw_pkg::SEQ_ASSERT : spbw_pkg::SEQ_DRIVE;
            end
         end
         spbw_pkg::SEQ_PRESET:
            if (step_done) next_s.st = spbw_pkg::SEQ_IDLE;
         spbw_pkg::SEQ_DRIVE:
            // The strobe is requested only once the data byte is confirmed on the port.
            if (step_done)
            begin
               next_s.step = spbw_pkg::STEP_ASSERT;
               next_s.req_tgl = ~s.req_tgl;
               next_s.step_pend = 1'b1;
               next_s.st = spbw_pkg::SEQ_ASSERT;
            end
         spbw_pkg::SEQ_ASSERT:
            if (step_done)
            begin
               next_s.timer = hold_cycles(s.cmd_hi[7:0]);
               next_s.st = spbw_pkg::SEQ_HOLD;
            end
         spbw_pkg::SEQ_HOLD:
            if (s.timer != 20'h00000)
            begin
               next_s.timer = s.timer - 20'h00001;
            end
            else
            begin
               next_s.step = is_read ? spbw_pkg::STEP_SAMPLE : spbw_pkg::STEP_RELEASE;
               next_s.req_tgl = ~s.req_tgl;
               next_s.step_pend = 1'b1;
               next_s.st = is_read ? spbw_pkg::SEQ_SAMPLE : spbw_pkg::SEQ_RELEASE;
            end
         spbw_pkg::SEQ_SAMPLE:
            if (step_done)
            begin
               next_s.rd_byte = lnk.sample;
               next_s.step = spbw_pkg::STEP_RELEASE;
               next_s.req_tgl = ~s.req_tgl;
               next_s.step_pend = 1'b1;
               next_s.st = spbw_pkg::SEQ_RELEASE;
            end
         spbw_pkg::SEQ_RELEASE:
            if (step_done)
            begin
               if (!is_read && s.left != 2'h0)
               begin
                  next_s.timer = gap_cycles(s.gap_del);
                  next_s.st = spbw_pkg::SEQ_GAP;
               end
               else
               begin
                  finish = 1'b1;
               end
            end
         spbw_pkg::SEQ_GAP:
            if (s.timer != 20'h00000)
            begin
               next_s.timer = s.timer - 20'h00001;
            end
            else
            begin
               next_s.data = s.xq[7:0];
               next_s.xq = {8'h00, s.xq[23:8]};
               next_s.left = s.left - 2'h1;
               next_s.step = spbw_pkg::STEP_DRIVE;
               next_s.req_tgl = ~s.req_tgl;
               next_s.step_pend = 1'b1;
               next_s.st = spbw_pkg::SEQ_DRIVE;
            end
         default:
         begin
            next_s.st = spbw_pkg::SEQ_IDLE;
         end
      endcase

      // Completion posts the echoed opcode as response byte 0; other response bytes read as zero.
      if (finish)
      begin
         next_s.resp0 = opcode;
         next_s.busy = 1'b0;
         next_s.done = 1'b1;
         next_s.st = spbw_pkg::SEQ_IDLE;
      end
   end

   // Single state register; reset values come from the register map.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s <= '0;
         s.hreadyout <= 1'b1;
         s.cmd_lo <= `SPBW_REG_RST;
         s.cmd_hi <= `SPBW_REG_RST;
         s.xdata <= `SPBW_REG_RST;
         s.lines <= `SPBW_REG_RST;
         s.st <= spbw_pkg::SEQ_IDLE;
         s.step <= spbw_pkg::STEP_PRESET;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign hrdata = s.hrdata;
   assign hreadyout = s.hreadyout;
   assign hresp = s.hresp;
endmodule

// [bench/spbw_props.sv]
`timescale 1ns/1ps
`include "spbw_map.svh"
module spbw_props (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic link_clk,
   input wire logic [7:0] port_a_out,
   input wire logic [7:0] port_a_oe,
   input wire logic [7:0] port_b_out,
   input wire logic [7:0] port_b_oe
);
   logic rd_ph;
   logic [7:0] rd_adr;
   // Note each read so its data phase can be judged.
   always_ff @(posedge hclk)
   begin
      rd_ph <= hsel && htrans[1] && hready && !hwrite && hsize == 3'h2;
      rd_adr <= haddr[7:0];
   end
   wire st_rd = rd_ph && rd_adr == `SPBW_OFS_STATUS;
   ready_high_a: assert property (@(posedge hclk) disable iff (!hresetn) hreadyout)
      else $error("wait state inserted");
   okay_resp_a: assert property (@(posedge hclk) disable iff (!hresetn) hresp == 1'b0)
      else $error("error response seen");
   unmapped_zero_a: assert property (@(posedge hclk) disable iff (!hresetn) rd_ph && rd_adr >= 8'h18 |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   go_reads_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_ph && rd_adr == `SPBW_OFS_CTRL |-> !hrdata[31]) else $error("start bit reads back set");
   resp_echo_a: assert property (@(posedge hclk) disable iff (!hresetn)
      st_rd && hrdata[1] && !hrdata[2] |-> hrdata[15:8] inside {8'h0B, 8'h0C}) else $error("response not opcode");
   err_resp_a: assert property (@(posedge hclk) disable iff (!hresetn)
      st_rd && hrdata[2] |-> hrdata[15:8] == 8'h00 && !hrdata[0]) else $error("refused command answered");
   busy_done_a: assert property (@(posedge hclk) disable iff (!hresetn) st_rd |-> !(hrdata[0] && hrdata[1]))
      else $error("busy and done together");
   status_rsvd_a: assert property (@(posedge hclk) disable iff (!hresetn)
      st_rd |-> hrdata[7:3] == 5'h00 && hrdata[31:24] == 8'h00) else $error("status spare bits set");
   pins_reset_a: assert property (@(posedge link_clk) disable iff (!hresetn)
      $rose(hresetn) |-> {port_a_out, port_a_oe, port_b_out, port_b_oe} == 32'h0) else $error("pins driven at reset");
   done_c: cover property (@(posedge hclk) disable iff (!hresetn) st_rd && hrdata[1]);
   err_c: cover property (@(posedge hclk) disable iff (!hresetn) st_rd && hrdata[2]);
   unmapped_c: cover property (@(posedge hclk) disable iff (!hresetn) rd_ph && rd_adr >= 8'h18);
endmodule

bind spbw_top spbw_props chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .link_clk(link_clk), .port_a_out(port_a_out), .port_a_oe(port_a_oe), .port_b_out(port_b_out),
   .port_b_oe(port_b_oe));

// [bench/spbw_periph.sv]
`timescale 1ns/1ps
module spbw_periph (
   input wire logic hclk,
   input wire logic [3:0] line,
   input wire logic pos,
   input wire logic data_b,
   input wire logic [7:0] rd_val,
   input wire logic [7:0] port_a_out,
   input wire logic [7:0] port_a_oe,
   input wire logic [7:0] port_b_out,
   input wire logic [7:0] port_b_oe,
   output logic [7:0] port_a_in,
   output logic [7:0] port_b_in
);
   logic [15:0] lv, en;
   logic act;
   logic act_q = 1'b0;
   logic [7:0] dbyte, held;
   logic [7:0] got [$];
   int wid_q [$], gap_q [$];
   int cnt = 0, bad_hold = 0;
   // A strobe counts only while driven at its active level.
   assign lv = {port_b_out, port_a_out};
   assign en = {port_b_oe, port_a_oe};
   assign act = en[line] && lv[line] == pos;
   assign dbyte = data_b ? port_b_out : port_a_out;
   // Undriven pins invert outside the strobe, exposing a mistimed sample.
   assign port_a_in = (port_a_oe & port_a_out) | (~port_a_oe & (act ? rd_val : ~rd_val));
   assign port_b_in = (port_b_oe & port_b_out) | (~port_b_oe & (act ? rd_val : ~rd_val));
   // Latch at the leading edge; time widths and gaps in bus clocks.
   always @(posedge hclk)
   begin
      if (act && act_q && dbyte !== held)
         bad_hold++;
      if (act !== act_q)
      begin
         if (act)
         begin
            got.push_back(dbyte);
            held = dbyte;
            gap_q.push_back(cnt);
         end
         else
            wid_q.push_back(cnt);
         cnt = 1;
      end
      else
         cnt++;
      act_q <= act;
   end
endmodule

// [bench/strobed_port_byte_writer_tb.sv]
`timescale 1ns/1ps
`include "spbw_map.svh"
module strobed_port_byte_writer_tb;
   localparam int BASE = 4, STEP = 1, GAPU = 2;
   logic hclk = 1'b0, lclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp;
   logic [7:0] pai, pbi, pao, pae, pbo, pbe;
   logic [3:0] line = 4'h0;
   logic pos = 1'b0, dat_b = 1'b0;
   logic [7:0] rd_val = 8'h00;
   int num_errors = 0;
   int n_checks = 0;
   int seed = 32'hDB0E;
   // Periods of 10 ns and 15 ns make the crossings see a repeating pattern of phases.
   always #5 hclk = ~hclk;
   always #7.5 lclk = ~lclk;
   spbw_top #(.STROBE_BASE_CYC(BASE), .STROBE_STEP_CYC(STEP), .GAP_UNIT_CYC(GAPU)) dut_u (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .link_clk(lclk), .port_a_in(pai), .port_b_in(pbi), .port_a_out(pao), .port_a_oe(pae),
      .port_b_out(pbo), .port_b_oe(pbe));
   spbw_periph per_u (.hclk(hclk), .line(line), .pos(pos), .data_b(dat_b), .rd_val(rd_val),
      .port_a_out(pao), .port_a_oe(pae), .port_b_out(pbo), .port_b_oe(pbe), .port_a_in(pai), .port_b_in(pbi));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic rdy;
      do
         @(posedge hclk);
      while (hreadyout !== 1'b1);
   endtask

   // Read data is taken as the data phase ends.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy();
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   function automatic int wexp(input logic [7:0] len);
      return BASE + int'(len) * STEP;
   endfunction

   // Preset pins, run one command, judge status and the peripheral's log.
   task automatic op(input logic [7:0] opc, dat, prt, sel, len, input logic [1:0] cnt, input logic [7:0] del,
                     input logic [23:0] xd);
      logic [31:0] cmd, st;
      logic [15:0] dr, lv;
      logic [7:0] dbs [4];
      int n;
      cmd = {sel, prt, dat, opc};
      dbs = '{dat, xd[7:0], xd[15:8], xd[23:16]};
      dr = (16'h0001 << sel[3:0]) | (opc == 8'h0B ? (prt[0] ? 16'hFF00 : 16'h00FF) : 16'h0000);
      lv = (sel[4] ? 16'h0000 : 16'h0001 << sel[3:0]) | (prt[0] ? {~dat, 8'h00} : {8'h00, ~dat});
      line <= sel[3:0];
      pos <= sel[4];
      dat_b <= prt[0];
      rd_val <= 8'($random(seed));
      wr(`SPBW_OFS_LINES, {dr, lv});
      repeat (12) @(posedge hclk);
      per_u.got.delete();
      per_u.wid_q.delete();
      per_u.gap_q.delete();
      per_u.bad_hold = 0;
      wr(`SPBW_OFS_CMD_LO, cmd);
      wr(`SPBW_OFS_CMD_HI, {24'($random(seed)), len});
      wr(`SPBW_OFS_XDATA, {8'h00, xd});
      wr(`SPBW_OFS_CTRL, {1'b1, 15'h0000, del, 6'h00, cnt});
      wr(`SPBW_OFS_CMD_LO, ~cmd);
      do
         bus(1'b0, `SPBW_OFS_STATUS, 32'h0, st);
      while (st[0] !== 1'b0);
      if (!((opc == 8'h0B || opc == 8'h0C) && prt <= 8'h01 && sel <= 8'h1F))
         chk({16'h0000, st[15:0]}, 32'h0004);
      else
      begin
         n = (opc == 8'h0B) ? int'(cnt) + 1 : 1;
         chk({16'h0000, st[15:0]}, {16'h0000, opc, 8'h02});
         chk(32'(per_u.got.size()), 32'(n));
         for (int k = 0; k < n && k < per_u.got.size(); k++)
         begin
            if (opc == 8'h0B)
               chk({24'h0, per_u.got[k]}, {24'h0, dbs[k]});
            chk(32'(per_u.wid_q[k] inside {[wexp(len):wexp(len) + 40]}), 32'h1);
            if (k > 0)
               chk(32'(per_u.gap_q[k] >= (int'(del) + 1) * GAPU), 32'h1);
         end
         if (opc == 8'h0C)
            chk({24'h0, st[23:16]}, {24'h0, rd_val});
         lv = {pbo, pao};
         chk({31'h0, lv[sel[3:0]]}, {31'h0, ~sel[4]});
         chk(32'(per_u.bad_hold), 32'h0);
         bus(1'b0, `SPBW_OFS_CMD_LO, 32'h0, st);
         chk(st, cmd);
      end
   endtask

   task automatic close_out;
      $display("checks %0d, mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Hang guard at 50000 clocks, far past the expected two thousand or so.
   initial
   begin
      #500000;
      num_errors++;
      close_out();
   end

   // Corners first, then random commands striking the spare port.
   initial
   begin
      logic [31:0] q;
      logic p;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, `SPBW_OFS_STATUS, 32'h0, q);
      chk(q, 32'h0);
      bus(1'b0, 8'h18, 32'h0, q);
      chk(q, 32'h0);
      op(8'h0B, 8'h55, 8'h00, 8'h0F, 8'h00, 2'h0, 8'h00, 24'h000000);
      op(8'h0B, 8'hAA, 8'h01, 8'h10, 8'hFF, 2'h3, 8'h00, 24'h5A3C96);
      op(8'h0C, 8'h00, 8'h00, 8'h1F, 8'h00, 2'h2, 8'h01, 24'h000000);
      op(8'h22, 8'h11, 8'h00, 8'h0F, 8'h00, 2'h0, 8'h00, 24'h000000);
      op(8'h0B, 8'h11, 8'h02, 8'h0F, 8'h00, 2'h0, 8'h00, 24'h000000);
      op(8'h0B, 8'h11, 8'h00, 8'h20, 8'h00, 2'h0, 8'h00, 24'h000000);
      for (int i = 0; i < 10; i++)
      begin
         p = 1'($random(seed));
         op($random(seed) % 2 ? 8'h0B : 8'h0C, 8'($random(seed)), {7'h00, p},
            {3'h0, 1'($random(seed)), ~p, 3'($random(seed))}, 8'($random(seed) & 7), 2'($random(seed)),
            8'($random(seed) & 3), 24'($random(seed)));
      end
      close_out();
   end
endmodule
